// ==== sst_pkg.sv ====
// package: register map, field positions and reset values of the smi/throttle slice
package sst_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [7:0] IDX_CTRL = 8'ha0;
    localparam logic [7:0] IDX_ENABLE = 8'ha2;
    localparam logic [7:0] IDX_IDLE = 8'ha8;
    localparam logic [7:0] IDX_STATUS = 8'haa;
    localparam logic [7:0] IDX_LOW = 8'hac;
    localparam logic [7:0] IDX_HIGH = 8'hae;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hb0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hb1;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_GATE_BIT = 0;
    localparam int CTRL_THROTTLE_BIT = 2;
    localparam int CTRL_IDLE_BIT = 3;
    localparam int ST_USB = 8;
    localparam int ST_APM = 7;
    localparam int ST_EXT = 6;
    localparam int ST_IDLE = 5;
    localparam int ST_EVENTS = 9;
    localparam int IRQ_SMI = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_RUN = 2;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [3:0] RST_CTRL = 4'h0;
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_STATUS = 16'h0000;
    localparam logic [7:0] RST_PERIOD = 8'h00;
    localparam logic [7:0] RST_IDLE = 8'h0f;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam int unsigned THR_UNIT_CLKS = 1056;
    localparam int THR_CNT_W = 19;
    typedef enum logic [1:0] {THR_OFF, THR_STOP, THR_RUN} sst_thr_e;
endpackage : sst_pkg

// ==== sst_sync_edge.sv ====
// two-flop pin synchroniser with rising edge detect per bit
`timescale 1ns/1ps
module sst_sync_edge #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] m1;
        logic [W-1:0] m2;
        logic [W-1:0] m3;
    } sst_sync_s;
    sst_sync_s st;
    sst_sync_s next_st;

    // ------------------------------------------------------------
    // shift chain; only m2 and m3 feed logic
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.m1 = d;
        next_st.m2 = st.m1;
        next_st.m3 = st.m2;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // one pulse per activation, however long the line stays high
    assign rise = st.m2 & ~st.m3;
endmodule : sst_sync_edge

// ==== sst_period_timer.sv ====
// down counter that times one clock-stop level
`timescale 1ns/1ps
module sst_period_timer #(
    parameter int W = 19
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
    } sst_tmr_s;
    sst_tmr_s st;
    sst_tmr_s next_st;

    // ------------------------------------------------------------
    // load wins over counting so a new level starts cleanly
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.cnt = load_val;
            next_st.run = 1'b1;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // done must not look at load: the caller derives load from done, which would loop
    assign done = st.run & (st.cnt == '0);
endmodule : sst_period_timer

// ==== sst_smi_throttle.sv ====
// smi event status register, clock throttle and apb register file
`timescale 1ns/1ps
module sst_smi_throttle #(
    parameter int unsigned THR_UNIT = sst_pkg::THR_UNIT_CLKS,
    parameter bit USB_LEGACY = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sst_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic usb_legacy_event,
    input wire logic apm_write_event,
    input wire logic external_smi_input_n,
    input wire logic irq_mouse,
    input wire logic irq_rtc_n,
    input wire logic irq_serial2,
    input wire logic irq_serial1,
    input wire logic irq_keyboard,
    output logic sys_mgmt_interrupt_n,
    output logic cpu_clock_stop_n,
    output logic irq
);
    import sst_pkg::*;

    localparam logic [15:0] STAT_MASK = USB_LEGACY ? 16'h01ff : 16'h00ff;
    localparam logic [THR_CNT_W-1:0] UNIT = THR_CNT_W'(THR_UNIT);

    typedef struct packed {
        sst_thr_e thr;
        logic [3:0] ctrl;
        logic [15:0] enable;
        logic [15:0] status;
        logic [7:0] low;
        logic [7:0] high;
        logic [7:0] idle_reload;
        logic [7:0] idle_cnt;
        logic [2:0] ist;
        logic [2:0] imsk;
        logic [1:0] int_prev;
        logic stop_n;
        logic smi_n;
        logic irq;
        logic [31:0] rdata;
        logic [THR_CNT_W-1:0] cur_len;
        logic [THR_CNT_W-1:0] seg_len;
    } sst_top_s;

    sst_top_s st;
    sst_top_s next_st;

    logic [5:0] pin_in;
    logic [5:0] pin_rise;
    logic [1:0] int_rise;
    logic idle_exp;
    logic [8:0] ev;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [7:0] idx;
    logic hit;
    logic acc;
    logic wr;
    logic [THR_CNT_W-1:0] lo_cnt;
    logic [THR_CNT_W-1:0] hi_cnt;
    logic tmr_load;
    logic [THR_CNT_W-1:0] tmr_val;
    logic tmr_done;
    logic [2:0] ist_set;

    // ------------------------------------------------------------
    // event capture
    // ------------------------------------------------------------
    // pins normalised active high before the synchroniser
    assign pin_in = {~external_smi_input_n, irq_mouse, ~irq_rtc_n,
                     irq_serial2, irq_serial1, irq_keyboard};

    // edge per assertion
    // edge capture only: a shared level line gives no second edge
    sst_sync_edge #(.W(6)) u_pins (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(pin_in),
        .rise(pin_rise)
    );

    assign int_rise = {usb_legacy_event, apm_write_event} & ~st.int_prev;

    assign idle_exp = st.ctrl[CTRL_IDLE_BIT] & (st.idle_cnt == 8'h00);

    assign ev = {int_rise, pin_rise[5], idle_exp, pin_rise[4:0]};

    assign set_vec = {7'h00, ev} & st.enable & STAT_MASK;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign idx = paddr[9:2];
    assign acc = psel & penable;
    assign wr = acc & pwrite & hit;

    always_comb begin
        hit = 1'b0;
        if (paddr[1:0] == 2'b00 && paddr[ADDR_W-1:10] == '0) begin
            case (idx)
                IDX_CTRL, IDX_ENABLE, IDX_IDLE, IDX_STATUS,
                IDX_LOW, IDX_HIGH, IDX_IRQ_STAT, IDX_IRQ_MASK: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
    end

    assign clr_vec = (wr && idx == IDX_STATUS) ? (~pwdata[15:0] & STAT_MASK) : 16'h0000;

    // zero wait states; unmapped access answers with an error
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;

    // ------------------------------------------------------------
    // throttle period lengths
    // ------------------------------------------------------------
    // level length minus one
    assign lo_cnt = UNIT * (THR_CNT_W'(st.low) + 1'b1);
    assign hi_cnt = UNIT * (THR_CNT_W'(st.high) + 1'b1);

    sst_period_timer #(.W(THR_CNT_W)) u_tmr (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        tmr_load = 1'b0;
        tmr_val = lo_cnt;
        ist_set = 3'h0;
        next_st.int_prev = {usb_legacy_event, apm_write_event};

        next_st.status = (st.status & ~clr_vec) | set_vec;

        // reload on expiry, counting again next clock
        if (!st.ctrl[CTRL_IDLE_BIT] || idle_exp) begin
            next_st.idle_cnt = st.idle_reload;
        end else begin
            next_st.idle_cnt = st.idle_cnt - 8'h01;
        end

        // register writes
        if (wr) begin
            case (idx)
                IDX_CTRL: next_st.ctrl = pwdata[3:0];
                IDX_ENABLE: next_st.enable = pwdata[15:0] & STAT_MASK;
                IDX_IDLE: next_st.idle_reload = pwdata[7:0];
                IDX_LOW: next_st.low = pwdata[7:0];
                IDX_HIGH: next_st.high = pwdata[7:0];
                IDX_IRQ_MASK: next_st.imsk = pwdata[2:0];
                default: next_st.imsk = next_st.imsk;
            endcase
        end

        // clearing the enable bit wins in any state so software can always stop throttling
        // throttle sequence
        case (st.thr)
            THR_OFF: begin
                if (st.ctrl[CTRL_THROTTLE_BIT]) begin
                    next_st.thr = THR_STOP;
                    next_st.stop_n = 1'b0;
                    tmr_load = 1'b1;
                end
            end
            THR_STOP: begin
                if (!st.ctrl[CTRL_THROTTLE_BIT]) begin
                    next_st.thr = THR_OFF;
                    next_st.stop_n = 1'b1;
                end else if (tmr_done) begin
                    next_st.thr = THR_RUN;
                    next_st.stop_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = hi_cnt;
                end
            end
            THR_RUN: begin
                if (!st.ctrl[CTRL_THROTTLE_BIT]) begin
                    next_st.thr = THR_OFF;
                end else if (tmr_done) begin
                    next_st.thr = THR_STOP;
                    next_st.stop_n = 1'b0;
                    tmr_load = 1'b1;
                end
            end
            default: begin
                next_st.thr = THR_OFF;
                next_st.stop_n = 1'b1;
            end
        endcase
        if (tmr_load) begin
            next_st.cur_len = tmr_val + 1'b1;
        end
        if (next_st.thr == THR_OFF || next_st.stop_n != st.stop_n) begin
            next_st.seg_len = THR_CNT_W'(1);
        end else begin
            next_st.seg_len = st.seg_len + 1'b1;
        end

        // interrupt: sticky events, cleared by reading what was seen
        // a set in the clearing cycle survives even if the bit was already up
        ist_set[IRQ_SMI] = |set_vec;
        ist_set[IRQ_STOP] = st.stop_n & ~next_st.stop_n;
        ist_set[IRQ_RUN] = ~st.stop_n & next_st.stop_n & (next_st.thr != THR_OFF);
        next_st.ist = st.ist | ist_set;
        if (acc && !pwrite && idx == IDX_IRQ_STAT && hit) begin
            next_st.ist = (st.ist & ~st.rdata[2:0]) | ist_set;
        end
        next_st.irq = |(next_st.ist & next_st.imsk);

        // smi follows status under the global gate
        next_st.smi_n = ~(next_st.ctrl[CTRL_GATE_BIT] & |next_st.status);

        // read data captured in the setup phase
        if (psel && !penable) begin
            case (idx)
                IDX_CTRL: next_st.rdata = {28'h0, st.ctrl};
                IDX_ENABLE: next_st.rdata = {16'h0, st.enable};
                IDX_IDLE: next_st.rdata = {24'h0, st.idle_reload};
                IDX_STATUS: next_st.rdata = {16'h0, st.status};
                IDX_LOW: next_st.rdata = {24'h0, st.low};
                IDX_HIGH: next_st.rdata = {24'h0, st.high};
                IDX_IRQ_STAT: next_st.rdata = {29'h0, st.ist};
                IDX_IRQ_MASK: next_st.rdata = {29'h0, st.imsk};
                default: next_st.rdata = 32'h0;
            endcase
            if (!hit) begin
                next_st.rdata = 32'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
            st.thr <= THR_OFF;
            st.ctrl <= RST_CTRL;
            st.enable <= RST_ENABLE;
            st.status <= RST_STATUS;
            st.low <= RST_PERIOD;
            st.high <= RST_PERIOD;
            st.idle_reload <= RST_IDLE;
            st.idle_cnt <= RST_IDLE;
            st.ist <= RST_IRQ;
            st.imsk <= RST_IRQ;
            st.stop_n <= 1'b1;
            st.smi_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign sys_mgmt_interrupt_n = st.smi_n;
    assign cpu_clock_stop_n = st.stop_n;
    assign irq = st.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (rst)
        (|set_vec) |=> ((st.status & $past(set_vec)) == $past(set_vec)))
        else $error("hardware set lost");
    AST_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        (|(clr_vec & ~set_vec)) |=> ((st.status & $past(clr_vec) & ~$past(set_vec)) == 16'h0000))
        else $error("status clear ignored");
    AST_ENABLE_ONLY: assert property (@(posedge clk_sys) disable iff (rst)
        ((st.status & ~$past(st.status) & ~$past(st.enable)) == 16'h0000))
        else $error("disabled source set status");
    AST_EDGE_ONCE: assert property (@(posedge clk_sys) disable iff (rst)
        ((st.status & ~$past(st.status) & ~$past(set_vec)) == 16'h0000))
        else $error("status set without event edge");
    AST_SMI_OUT: assert property (@(posedge clk_sys) disable iff (rst)
        ($rose(|st.status) && st.ctrl[CTRL_GATE_BIT]) |-> !sys_mgmt_interrupt_n)
        else $error("smi not raised");
    AST_LOAD_LOW: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(cpu_clock_stop_n) |-> (st.cur_len == $past(lo_cnt) + 1'b1))
        else $error("low period not loaded");
    AST_LOAD_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
        ($rose(cpu_clock_stop_n) && st.thr == THR_RUN) |-> (st.cur_len == $past(hi_cnt) + 1'b1))
        else $error("high period not loaded");
    AST_SEG_LEN: assert property (@(posedge clk_sys) disable iff (rst)
        ($changed(cpu_clock_stop_n) && $past(st.thr) != THR_OFF && st.thr != THR_OFF)
        |-> ($past(st.seg_len) == $past(st.cur_len)))
        else $error("throttle level length wrong");
    AST_IDLE_RESUME: assert property (@(posedge clk_sys) disable iff (rst)
        (idle_exp && st.idle_reload != 8'h00 && st.ctrl[CTRL_IDLE_BIT])
        ##1 st.ctrl[CTRL_IDLE_BIT] |-> ##1 (st.idle_cnt == $past(st.idle_cnt) - 8'h01))
        else $error("idle timer did not resume");
    AST_THR_OFF: assert property (@(posedge clk_sys) disable iff (rst)
        !st.ctrl[CTRL_THROTTLE_BIT] |=> cpu_clock_stop_n)
        else $error("clock stop held without throttle");
    AST_IRQ_STOP: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(cpu_clock_stop_n) |-> st.ist[IRQ_STOP])
        else $error("clock stop event not recorded");
    AST_IRQ_RUN: assert property (@(posedge clk_sys) disable iff (rst)
        ($rose(cpu_clock_stop_n) && st.thr == THR_RUN) |-> st.ist[IRQ_RUN])
        else $error("clock run event not recorded");
    AST_IDLE_GATED: assert property (@(posedge clk_sys) disable iff (rst)
        (!st.ctrl[CTRL_IDLE_BIT] && !st.status[ST_IDLE]) |=> !st.status[ST_IDLE])
        else $error("idle status set with timer stopped");
endmodule : sst_smi_throttle

// ==== sst_host_model.sv ====
// host-side model: watches the smi and clock-stop outputs, counts smi requests and times each clock-stop level
`timescale 1ns/1ps
module sst_host_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sys_mgmt_interrupt_n,
    input wire logic cpu_clock_stop_n,
    output int low_len,
    output int high_len,
    output int smi_cnt
);
    logic prev_stop_n;
    logic prev_smi_n;
    int run;

    // ------------------------------------------------------------
    // level timing
    // ------------------------------------------------------------
    // level length count
    // only complete levels are recorded, so a level still running never shows a short length
    always @(posedge clk_sys) begin
        if (rst) begin
            prev_stop_n <= 1'b1;
            prev_smi_n <= 1'b1;
            run <= 0;
            low_len <= 0;
            high_len <= 0;
            smi_cnt <= 0;
        end else begin
            prev_stop_n <= cpu_clock_stop_n;
            prev_smi_n <= sys_mgmt_interrupt_n;
            if (cpu_clock_stop_n === prev_stop_n) begin
                run <= run + 1;
            end else begin
                run <= 1;
                if (prev_stop_n === 1'b0) low_len <= run; // stop level just ended
                else high_len <= run;
            end
            if (prev_smi_n === 1'b1 && sys_mgmt_interrupt_n === 1'b0) smi_cnt <= smi_cnt + 1;
        end
    end
endmodule : sst_host_model

// ==== sst_smi_throttle_bench.sv ====
// self-checking bench for the smi status and clock throttle slice
`timescale 1ns/1ps
module sst_smi_throttle_bench;
    import sst_pkg::*;
    localparam int UNIT = 2;
    localparam int BIT_OF [0:7] = '{8, 7, 6, 4, 3, 2, 1, 0};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, smi_n, stop_n, irq, err;
    logic [7:0] ev = 8'h00; // active-high event levels, table order
    logic [31:0] rd;
    logic [31:0] lfsr = 32'h8ac5;
    int n_fail = 0;
    int num_checks = 0;
    int mdl_status = 0;
    int mdl_en = 0;
    int low_len, high_len, smi_cnt, lo, hi;

    sst_smi_throttle #(.THR_UNIT(UNIT), .USB_LEGACY(1'b1)) sst_smi_throttle_inst (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .usb_legacy_event(ev[0]), .apm_write_event(ev[1]), .external_smi_input_n(~ev[2]),
        .irq_mouse(ev[3]), .irq_rtc_n(~ev[4]), .irq_serial2(ev[5]), .irq_serial1(ev[6]),
        .irq_keyboard(ev[7]), .sys_mgmt_interrupt_n(smi_n), .cpu_clock_stop_n(stop_n), .irq(irq));

    sst_host_model sst_host_model_inst (.clk_sys(clk_sys), .rst(rst), .sys_mgmt_interrupt_n(smi_n),
        .cpu_clock_stop_n(stop_n), .low_len(low_len), .high_len(high_len), .smi_cnt(smi_cnt));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer; hit raises the apm event so its set lands on the access edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d, input logic hit);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        if (hit) ev[1] <= 1'b1;
        // no cycle count assumed; only the watchdog ends a wait
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys); // idle edge keeps psel from being driven twice in a step
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 1'b0);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string w);
        apb(1'b0, idx, 32'h0, 1'b0);
        chk(rd, exp, w);
    endtask : rdc

    // edge-only sources
    // each source gets a fresh edge of its own; no line is shared in level mode
    task automatic fire(input int i);
        ev[i] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        if (mdl_en & (1 << BIT_OF[i])) mdl_status |= (1 << BIT_OF[i]);
    endtask : fire

    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial forever #5 clk_sys = ~clk_sys;

    // a hang ends the run well past the longest sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdc(IDX_LOW, 32'h0, "low reset");
        rdc(IDX_HIGH, 32'h0, "high reset");
        rdc(IDX_STATUS, 32'h0, "status reset");
        apb(1'b0, 8'h10, 32'h0, 1'b0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        // disabled sources must leave status and smi quiet
        ev <= 8'hff;
        repeat (6) @(posedge clk_sys);
        rdc(IDX_STATUS, 32'h0, "disabled sources");
        chk({31'h0, smi_n}, 32'h1, "smi idle");
        ev <= 8'h00;
        repeat (6) @(posedge clk_sys);
        mdl_en = 32'h1df;
        wr(IDX_ENABLE, mdl_en);
        wr(IDX_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) begin
            fire(i);
            rdc(IDX_STATUS, mdl_status, "event sets bit");
        end
        chk({31'h0, smi_n}, 32'h0, "smi low with gate");
        chk(smi_cnt, 32'h1, "one smi request");
        wr(IDX_CTRL, 32'h0);
        chk({31'h0, smi_n}, 32'h1, "smi off without gate");
        rdc(IDX_STATUS, mdl_status, "status kept without gate");
        // clear one bit at a time while every source is still active
        for (int i = 0; i < 8; i++) begin
            wr(IDX_STATUS, ~(32'h1 << BIT_OF[i]));
            mdl_status &= ~(1 << BIT_OF[i]);
            repeat (4) @(posedge clk_sys);
            rdc(IDX_STATUS, mdl_status, "single clear");
        end
        ev <= 8'h00;
        repeat (6) @(posedge clk_sys);
        fire(1);
        ev[1] <= 1'b0;
        repeat (2) @(posedge clk_sys);
        apb(1'b1, IDX_STATUS, 32'hffffff7f, 1'b1);
        rdc(IDX_STATUS, mdl_status, "set beats clear");
        ev <= 8'h00;
        wr(IDX_STATUS, 32'h0);
        mdl_status = 0;
        // interrupt: raise, clear by read, then masked
        apb(1'b0, IDX_IRQ_STAT, 32'h0, 1'b0);
        wr(IDX_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h0, "irq idle");
        fire(7);
        chk({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b0, IDX_IRQ_STAT, 32'h0, 1'b0);
        chk({31'h0, rd[0]}, 32'h1, "irq status bit");
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0, "irq cleared by read");
        ev <= 8'h00;
        wr(IDX_STATUS, 32'h0);
        wr(IDX_IRQ_MASK, 32'h0);
        fire(7);
        chk({31'h0, irq}, 32'h0, "irq masked");
        ev <= 8'h00;
        // idle timer expiry sets bit 5 and keeps counting
        wr(IDX_ENABLE, 32'h20);
        wr(IDX_IDLE, 32'h3);
        wr(IDX_CTRL, 32'h8);
        repeat (20) @(posedge clk_sys);
        rdc(IDX_STATUS, 32'h21, "idle expiry");
        wr(IDX_STATUS, 32'h0);
        repeat (20) @(posedge clk_sys);
        rdc(IDX_STATUS, 32'h20, "idle resumes");
        wr(IDX_CTRL, 32'h0);
        wr(IDX_STATUS, 32'h0);
        rdc(IDX_STATUS, 32'h0, "idle stopped");
        // throttle with random periods, changed in mid-run
        for (int r = 0; r < 3; r++) begin
            lfsr = nxt(nxt(lfsr));
            lo = lfsr[1:0];
            hi = lfsr[3:2];
            wr(IDX_LOW, lo);
            wr(IDX_HIGH, hi);
            rdc(IDX_HIGH, hi, "high readback");
            if (r == 0) wr(IDX_CTRL, 32'h4);
            repeat (60) @(posedge clk_sys);
            chk(low_len, 1 + UNIT * (lo + 1), "stop level length");
            chk(high_len, 1 + UNIT * (hi + 1), "run level length");
        end
        wr(IDX_IRQ_MASK, 32'h6);
        chk({31'h0, irq}, 32'h1, "irq on throttle levels");
        apb(1'b0, IDX_IRQ_STAT, 32'h0, 1'b0);
        chk({30'h0, rd[2:1]}, 32'h3, "throttle level events");
        wr(IDX_CTRL, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, stop_n}, 32'h1, "throttle off");
        wrap_up();
    end
endmodule : sst_smi_throttle_bench
